/* hdl/failover_if.sv */
// carrier between failover core and its timing unit
`timescale 1ns/10ps
`default_nettype none
interface failover_if;
	logic strobe_a;
	logic strobe_b;
	logic [3:0] clock_hold;
	logic delayed_start_0;
	logic delayed_start_1;
	logic update_inhibit_0;
	logic update_inhibit_1;
	logic [3:0] mask;
	logic verify_clamp;
	modport core (output strobe_a, output strobe_b, input clock_hold, input delayed_start_0,
		input delayed_start_1, input update_inhibit_0, input update_inhibit_1, input mask, input verify_clamp);
	modport timing (input strobe_a, input strobe_b, output clock_hold, output delayed_start_0,
		output delayed_start_1, output update_inhibit_0, output update_inhibit_1, output mask,
		output verify_clamp);
endinterface
`default_nettype wire

/* hdl/failover_map.svh */
// constants of the data link failover transfer block
`ifndef FAILOVER_MAP_SVH
`define FAILOVER_MAP_SVH
`define FO_CLK_KHZ 125000
`define FO_STROBE_NS 80
`define FO_STROBE_CYCLES ((`FO_STROBE_NS * 125) / 1000)
`define FO_START_US 10
`define FO_START_CYCLES (`FO_START_US * 125)
`define FO_DELAY_MS 100
`define FO_DELAY_CYCLES (`FO_DELAY_MS * `FO_CLK_KHZ)
`define FO_UPDATE_MS 220
`define FO_UPDATE_CYCLES (`FO_UPDATE_MS * `FO_CLK_KHZ)
`define FO_MASK_MS 18
`define FO_MASK_CYCLES (`FO_MASK_MS * `FO_CLK_KHZ)
`define FO_HOLD_MS 100
`define FO_HOLD_CYCLES (`FO_HOLD_MS * `FO_CLK_KHZ)
`define FO_CHAIN_LEN 6
`define FO_RELAY_RESET 2'b11
`endif

/* hdl/failover_pkg.sv */
// types of the data link failover transfer block
package failover_pkg;
	typedef enum logic [1:0] {
		pwr_clock0,
		pwr_drop0,
		pwr_clock1,
		pwr_drop1
	} power_state_e;
	typedef logic [31:0] count_t;
endpackage

/* hdl/failover_timing.sv */
// monopulser chain: clock holds, delayed starts, update inhibit, masks, clamp
`timescale 1ns/10ps
`default_nettype none
`include "failover_map.svh"
module failover_timing
	import failover_pkg::*;
#(
	parameter count_t HOLD_CYCLES = `FO_HOLD_CYCLES,
	parameter count_t DELAY_CYCLES = `FO_DELAY_CYCLES,
	parameter count_t UPDATE_CYCLES = `FO_UPDATE_CYCLES,
	parameter count_t MASK_CYCLES = `FO_MASK_CYCLES
) (
	input wire logic clock,
	input wire logic rst_b,
	failover_if.timing tif
);
	localparam count_t START_CYCLES = `FO_START_CYCLES;
	count_t hold_cnt [2];
	count_t delay_cnt [2];
	count_t start_cnt [2];
	count_t update_cnt [2];
	count_t mask_cnt [2];
	logic [1:0] trig;
	logic [1:0] update_end;

	function automatic count_t next_count(input count_t cnt, input logic load, input count_t len);
		if (load) begin
			return len;
		end
		return (cnt != '0) ? cnt - 32'h0000_0001 : cnt;
	endfunction

	assign trig = {tif.strobe_b, tif.strobe_a};
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			update_end[i] = (update_cnt[i] == 32'h0000_0001);
		end
	end

	// each channel retriggers from its own strobe, as a monopulser would
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 2; i++) begin
				hold_cnt[i] <= '0;
				delay_cnt[i] <= '0;
				start_cnt[i] <= '0;
				update_cnt[i] <= '0;
				mask_cnt[i] <= '0;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				hold_cnt[i] <= next_count(hold_cnt[i], trig[i], HOLD_CYCLES);
				delay_cnt[i] <= next_count(delay_cnt[i], trig[i], DELAY_CYCLES);
				start_cnt[i] <= next_count(start_cnt[i], delay_cnt[i] == 32'h0000_0001, START_CYCLES);
				update_cnt[i] <= next_count(update_cnt[i], delay_cnt[i] == 32'h0000_0001, UPDATE_CYCLES);
				mask_cnt[i] <= next_count(mask_cnt[i], trig[i], MASK_CYCLES);
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tif.clock_hold <= 4'h0;
			tif.delayed_start_0 <= 1'b0;
			tif.delayed_start_1 <= 1'b0;
			tif.update_inhibit_0 <= 1'b0;
			tif.update_inhibit_1 <= 1'b0;
			tif.mask <= 4'h0;
		end else begin
			tif.clock_hold <= {4{(hold_cnt[0] != '0) || (hold_cnt[1] != '0)}};
			tif.delayed_start_0 <= (start_cnt[0] != '0);
			tif.delayed_start_1 <= (start_cnt[1] != '0);
			tif.update_inhibit_0 <= (update_cnt[0] != '0);
			tif.update_inhibit_1 <= (update_cnt[1] != '0);
			tif.mask <= {{2{mask_cnt[1] != '0}}, {2{mask_cnt[0] != '0}}};
		end
	end

	// a new strobe in the clearing cycle keeps the clamp set
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tif.verify_clamp <= 1'b0;
		end else if (|trig) begin
			tif.verify_clamp <= 1'b1;
		end else if (|update_end) begin
			tif.verify_clamp <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* hdl/link_failover.sv */
// data link failover transfer: relay supervision, routing and common handover
`timescale 1ns/10ps
`default_nettype none
`include "failover_map.svh"
module link_failover
	import failover_pkg::*;
#(
	parameter count_t HOLD_CYCLES = `FO_HOLD_CYCLES,
	parameter count_t DELAY_CYCLES = `FO_DELAY_CYCLES,
	parameter count_t UPDATE_CYCLES = `FO_UPDATE_CYCLES,
	parameter count_t MASK_CYCLES = `FO_MASK_CYCLES
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic link1_supervision_relay,
	input wire logic link3_supervision_relay,
	input wire logic link3_in,
	input wire logic trunk13_pair_in,
	input wire logic tx2_line_in,
	input wire logic spare_tx_line_in,
	input wire logic trunk14_circuit_in,
	input wire logic rx2_bit,
	input wire logic rx2_data,
	input wire logic spare_rx_bit,
	input wire logic spare_rx_data,
	input wire logic tx_out_second_0,
	input wire logic tx_out_second_1,
	input wire logic counter_a_jam_0,
	input wire logic counter_a_jam_1,
	input wire logic counter_b_jam_0,
	input wire logic counter_b_jam_1,
	input wire logic clock_sync_pulse_0,
	input wire logic clock_sync_pulse_1,
	input wire logic quiet_scan_src_0,
	input wire logic quiet_scan_src_1,
	input wire logic [10:0] maint_src_0,
	input wire logic [10:0] maint_src_1,
	input wire logic [10:0] clock_strobe_0,
	input wire logic [10:0] clock_strobe_1,
	input wire logic scanner_active,
	output logic rx2_line,
	output logic trunk13_circuit_line,
	output logic spare_rx_line,
	output logic link3_out,
	output logic trunk14_pair_out,
	output logic tx2_in_service,
	output logic rx_bit_in_3,
	output logic rx_data_in_3,
	output logic rx_bit_in_2,
	output logic rx_data_in_2,
	output logic [1:0] tx2_feed,
	output logic [1:0] spare_tx_feed,
	output logic [1:0] counter_a_jam,
	output logic [1:0] counter_b_jam,
	output logic [3:0] clock_sync,
	output logic quiet_scan_0,
	output logic quiet_scan_1,
	output logic [10:0] maint_line,
	output logic [10:0] switch_strobe_0,
	output logic [10:0] switch_strobe_1,
	output logic clock0_power,
	output logic clock0_ground,
	output logic clock1_power,
	output logic clock1_ground,
	output logic failover_strobe_a,
	output logic failover_strobe_b,
	output logic [3:0] clock_hold,
	output logic delayed_start_0,
	output logic delayed_start_1,
	output logic update_inhibit_0,
	output logic update_inhibit_1,
	output logic message_send_hold,
	output logic [3:0] mask,
	output logic verify_clamp,
	output logic verify_261,
	output logic scan_point_260,
	output logic second_link_transfer,
	output logic common_transfer
);
	localparam logic [4:0] STROBE_LEN = 5'(`FO_STROBE_CYCLES);
	failover_if fif ();
	logic [1:0] relay;
	logic [1:0] relay_last;
	logic [4:0] strobe_cnt_a;
	logic [4:0] strobe_cnt_b;
	logic next_second;
	logic next_common;
	logic [`FO_CHAIN_LEN-1:0] chain;
	power_state_e power_state;
	power_state_e next_power_state;

	relay_input_sync u_sync (
		.clock(clock),
		.rst_b(rst_b),
		.raw({link3_supervision_relay, link1_supervision_relay}),
		.stable(relay)
	);

	failover_timing #(
		.HOLD_CYCLES(HOLD_CYCLES),
		.DELAY_CYCLES(DELAY_CYCLES),
		.UPDATE_CYCLES(UPDATE_CYCLES),
		.MASK_CYCLES(MASK_CYCLES)
	) u_timing (
		.clock(clock),
		.rst_b(rst_b),
		.tif(fif.timing)
	);

	function automatic logic [4:0] strobe_step(input logic [4:0] cnt, input logic changed);
		if (changed) begin
			return STROBE_LEN;
		end
		return (cnt != 5'h00) ? cnt - 5'h01 : cnt;
	endfunction

	// relay 1 = operated (dc present); a released relay reads 0
	assign next_second = !relay[1] && relay[0];
	assign next_common = relay[1] ^ relay[0];

	// break-make contact shows a brief pulse on each change-over
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			relay_last <= `FO_RELAY_RESET;
			strobe_cnt_a <= 5'h00;
			strobe_cnt_b <= 5'h00;
			failover_strobe_a <= 1'b0;
			failover_strobe_b <= 1'b0;
		end else begin
			relay_last <= relay;
			strobe_cnt_a <= strobe_step(strobe_cnt_a, relay[0] != relay_last[0]);
			strobe_cnt_b <= strobe_step(strobe_cnt_b, relay[1] != relay_last[1]);
			failover_strobe_a <= (strobe_cnt_a != 5'h00);
			failover_strobe_b <= (strobe_cnt_b != 5'h00);
		end
	end

	// timing unit sees only the leading edge so one change-over is one trigger
	assign fif.strobe_a = (relay[0] != relay_last[0]);
	assign fif.strobe_b = (relay[1] != relay_last[1]);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			second_link_transfer <= 1'b0;
			common_transfer <= 1'b0;
			chain <= '0;
		end else begin
			second_link_transfer <= next_second;
			common_transfer <= next_common;
			// series chain picks up one relay at a time, drops at once
			chain <= next_common ? {chain[`FO_CHAIN_LEN-2:0], 1'b1} : '0;
		end
	end

	// second-link routing of lines, receivers and transmitters
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rx2_line <= 1'b0;
			trunk13_circuit_line <= 1'b0;
			spare_rx_line <= 1'b0;
			link3_out <= 1'b0;
			trunk14_pair_out <= 1'b0;
			tx2_in_service <= 1'b1;
			rx_bit_in_3 <= 1'b0;
			rx_data_in_3 <= 1'b0;
			rx_bit_in_2 <= 1'b0;
			rx_data_in_2 <= 1'b0;
			tx2_feed <= 2'h0;
			spare_tx_feed <= 2'h0;
		end else if (second_link_transfer) begin
			rx2_line <= 1'b0;
			trunk13_circuit_line <= link3_in;
			spare_rx_line <= trunk13_pair_in;
			link3_out <= trunk14_circuit_in;
			trunk14_pair_out <= spare_tx_line_in;
			tx2_in_service <= 1'b0;
			rx_bit_in_3 <= 1'b0;
			rx_data_in_3 <= 1'b0;
			rx_bit_in_2 <= spare_rx_bit;
			rx_data_in_2 <= spare_rx_data;
			tx2_feed <= 2'h0;
			spare_tx_feed <= {tx_out_second_1, tx_out_second_0};
		end else begin
			rx2_line <= link3_in;
			trunk13_circuit_line <= trunk13_pair_in;
			spare_rx_line <= 1'b0;
			link3_out <= tx2_line_in;
			trunk14_pair_out <= trunk14_circuit_in;
			tx2_in_service <= 1'b1;
			rx_bit_in_3 <= rx2_bit;
			rx_data_in_3 <= rx2_data;
			rx_bit_in_2 <= 1'b0;
			rx_data_in_2 <= 1'b0;
			tx2_feed <= {tx_out_second_1, tx_out_second_0};
			spare_tx_feed <= 2'h0;
		end
	end

	// common handover of synchronising, scan and maintenance leads
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			counter_a_jam <= 2'h0;
			counter_b_jam <= 2'h0;
			clock_sync <= 4'h0;
			quiet_scan_0 <= 1'b0;
			quiet_scan_1 <= 1'b0;
			maint_line <= 11'h000;
		end else begin
			// the idle OR input is always grounded
			counter_a_jam <= common_transfer ? {counter_a_jam_1, 1'b0} : {1'b0, counter_a_jam_0};
			counter_b_jam <= common_transfer ? {counter_b_jam_1, 1'b0} : {1'b0, counter_b_jam_0};
			clock_sync <= {4{common_transfer ? clock_sync_pulse_1 : clock_sync_pulse_0}};
			quiet_scan_0 <= common_transfer ? 1'b0 : quiet_scan_src_0;
			quiet_scan_1 <= common_transfer ? quiet_scan_src_1 : 1'b0;
			maint_line <= common_transfer ? maint_src_1 : maint_src_0;
		end
	end

	// clock handover: never both clocks powered, one dead cycle between them
	always_comb begin
		next_power_state = power_state;
		unique case (power_state)
			pwr_clock0: begin
				if (common_transfer) begin
					next_power_state = pwr_drop0;
				end
			end
			pwr_drop0: begin
				next_power_state = common_transfer ? pwr_clock1 : pwr_clock0;
			end
			pwr_clock1: begin
				if (!common_transfer) begin
					next_power_state = pwr_drop1;
				end
			end
			pwr_drop1: begin
				next_power_state = common_transfer ? pwr_clock1 : pwr_clock0;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			power_state <= pwr_clock0;
		end else begin
			power_state <= next_power_state;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			clock0_power <= 1'b1;
			clock0_ground <= 1'b0;
			clock1_power <= 1'b0;
			clock1_ground <= 1'b1;
			switch_strobe_0 <= 11'h000;
			switch_strobe_1 <= 11'h000;
		end else begin
			clock0_power <= (next_power_state == pwr_clock0);
			clock0_ground <= (next_power_state != pwr_clock0);
			clock1_power <= (next_power_state == pwr_clock1);
			clock1_ground <= (next_power_state != pwr_clock1);
			switch_strobe_0 <= (power_state == pwr_clock0) ? clock_strobe_0 : 11'h000;
			switch_strobe_1 <= (power_state == pwr_clock1) ? clock_strobe_1 : 11'h000;
		end
	end

	// timing results and scan points
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			clock_hold <= 4'h0;
			delayed_start_0 <= 1'b0;
			delayed_start_1 <= 1'b0;
			update_inhibit_0 <= 1'b0;
			update_inhibit_1 <= 1'b0;
			message_send_hold <= 1'b0;
			mask <= 4'h0;
			verify_clamp <= 1'b0;
			verify_261 <= 1'b0;
			scan_point_260 <= 1'b0;
		end else begin
			clock_hold <= fif.clock_hold;
			delayed_start_0 <= fif.delayed_start_0;
			delayed_start_1 <= fif.delayed_start_1;
			update_inhibit_0 <= fif.update_inhibit_0;
			update_inhibit_1 <= fif.update_inhibit_1;
			message_send_hold <= fif.update_inhibit_0 || fif.update_inhibit_1;
			mask <= fif.mask;
			verify_clamp <= fif.verify_clamp;
			verify_261 <= (&chain) && !fif.verify_clamp;
			scan_point_260 <= scanner_active;
		end
	end
endmodule
`default_nettype wire

/* hdl/relay_input_sync.sv */
// three-stage synchroniser for the supervision relay contacts
`timescale 1ns/10ps
`default_nettype none
`include "failover_map.svh"
module relay_input_sync
	import failover_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [1:0] raw,
	output logic [1:0] stable
);
	logic [1:0] meta;
	logic [1:0] mid;
	logic [1:0] late;

	// resets to operated: a dead link must first be seen before transfer
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			meta <= `FO_RELAY_RESET;
			mid <= `FO_RELAY_RESET;
			late <= `FO_RELAY_RESET;
		end else begin
			meta <= raw;
			mid <= meta;
			late <= mid;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			stable <= `FO_RELAY_RESET;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (mid[i] == late[i]) begin
					stable[i] <= late[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

/* tb/control_unit_model.sv */
// far-side model: dc feed on link pairs one and three, data on link three
`timescale 1ns/10ps
`default_nettype none
module control_unit_model (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [1:0] dc_on,
	input wire logic [3:0] lag,
	output logic link1_supervision_relay,
	output logic link3_supervision_relay,
	output logic link3_in
);
	logic [15:0] h1, h3, prbs;
	// relays follow the dc feed after a settable lag, so slow links are covered
	always_ff @(posedge clock or negedge rst_b)
		if (!rst_b) begin
			h1 <= 16'hffff;
			h3 <= 16'hffff;
		end else begin
			h1 <= {h1[14:0], dc_on[0]};
			h3 <= {h3[14:0], dc_on[1]};
		end
	// line data is a fresh LFSR bit every cycle, so a stale level passes as routed only by chance
	always_ff @(posedge clock or negedge rst_b)
		if (!rst_b)
			prbs <= 16'hace1;
		else
			prbs <= {prbs[14:0], prbs[15] ^ prbs[14] ^ prbs[12] ^ prbs[3]};
	assign link1_supervision_relay = h1[lag];
	assign link3_supervision_relay = h3[lag];
	assign link3_in = prbs[0];
endmodule
`default_nettype wire

/* tb/data_link_failover_transfer_test.sv */
// self-checking bench of the link failover block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; $display("unexpected %s: expected %h, seen %h", n, e, g); end end
module data_link_failover_transfer_test;
	localparam int HD = 20, DL = 30, UP = 40, MK = 15;
	logic clock = 0, rst_b = 0;
	logic link1_supervision_relay, link3_supervision_relay, link3_in, trunk13_pair_in, tx2_line_in, spare_tx_line_in;
	logic trunk14_circuit_in, rx2_bit, rx2_data, spare_rx_bit, spare_rx_data, tx_out_second_0, tx_out_second_1;
	logic counter_a_jam_0, counter_a_jam_1, counter_b_jam_0, counter_b_jam_1, clock_sync_pulse_0, clock_sync_pulse_1;
	logic quiet_scan_src_0, quiet_scan_src_1, scanner_active, rx2_line, trunk13_circuit_line, spare_rx_line;
	logic [10:0] maint_src_0, maint_src_1, clock_strobe_0, clock_strobe_1, maint_line, switch_strobe_0, switch_strobe_1;
	logic link3_out, trunk14_pair_out, tx2_in_service, rx_bit_in_3, rx_data_in_3, rx_bit_in_2, rx_data_in_2;
	logic quiet_scan_0, quiet_scan_1, clock0_power, clock0_ground, clock1_power, clock1_ground, failover_strobe_a;
	logic failover_strobe_b, delayed_start_0, delayed_start_1, update_inhibit_0, update_inhibit_1, message_send_hold;
	logic verify_clamp, verify_261, scan_point_260, second_link_transfer, common_transfer;
	logic [1:0] tx2_feed, spare_tx_feed, counter_a_jam, counter_b_jam, dc_on = 2'h3;
	logic [3:0] clock_sync, clock_hold, mask, lag = 4'h0;
	logic [63:0] r = 64'h0000_0000_0001_74aa;
	bit s, c;
	int fail_count, checks, run[10], w[10];
	wire [9:0] mon = {message_send_hold, clock_hold[3], update_inhibit_1, delayed_start_1, mask[2], failover_strobe_b,
		update_inhibit_0, delayed_start_0, mask[0], failover_strobe_a};
	link_failover #(.HOLD_CYCLES(HD), .DELAY_CYCLES(DL), .UPDATE_CYCLES(UP), .MASK_CYCLES(MK)) dut (.*);
	control_unit_model far (.clock(clock), .rst_b(rst_b), .dc_on(dc_on), .lag(lag),
		.link1_supervision_relay(link1_supervision_relay), .link3_supervision_relay(link3_supervision_relay),
		.link3_in(link3_in));
	always #4 clock = ~clock;
	// pulse widths measured in cycles, kept at each falling edge
	always @(posedge clock)
		for (int i = 0; i < 10; i++)
			if (mon[i] === 1'b1)
				run[i] <= run[i] + 1;
			else begin
				if (run[i] != 0)
					w[i] <= run[i];
				run[i] <= 0;
			end
	function automatic logic [63:0] step(input logic [63:0] v);
		return {v[62:0], v[63] ^ v[62] ^ v[60] ^ v[59]};
	endfunction
	function automatic int exp_w(input int i, input bit sb);
		int t[4] = '{10, MK, 1250, UP};
		if (i > 7)
			return i == 8 ? HD : UP;
		return i / 4 == int'(sb) ? t[i % 4] : 0;
	endfunction
	task automatic put(input logic [62:0] v);
		{trunk13_pair_in, tx2_line_in, spare_tx_line_in, trunk14_circuit_in, rx2_bit, rx2_data, spare_rx_bit,
			spare_rx_data, tx_out_second_1, tx_out_second_0, counter_a_jam_1, counter_a_jam_0, counter_b_jam_1,
			counter_b_jam_0, clock_sync_pulse_1, clock_sync_pulse_0, quiet_scan_src_1, quiet_scan_src_0,
			scanner_active, maint_src_1, maint_src_0, clock_strobe_1, clock_strobe_0} = v;
	endtask
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// all-zero and all-one vectors first, random ones after
	task automatic cyc(input int n, input string name);
		logic l3;
		for (int i = 0; i < n; i++) begin
			r = step(r);
			put(i == 0 ? 63'h0 : i == 1 ? 63'h7fff_ffff_ffff_ffff : r[62:0]);
			l3 = link3_in;
			@(posedge clock);
			#1;
			`CHK("second_link_transfer", s, second_link_transfer)
			`CHK("common_transfer", c, common_transfer)
			`CHK("rx2_line", s ? 1'h0 : l3, rx2_line)
			`CHK("trunk13_circuit_line", s ? l3 : trunk13_pair_in, trunk13_circuit_line)
			`CHK("spare_rx_line", s ? trunk13_pair_in : 1'h0, spare_rx_line)
			`CHK("link3_out", s ? trunk14_circuit_in : tx2_line_in, link3_out)
			`CHK("trunk14_pair_out", s ? spare_tx_line_in : trunk14_circuit_in, trunk14_pair_out)
			`CHK("tx2_in_service", !s, tx2_in_service)
			`CHK("rx inputs", s ? {2'h0, spare_rx_bit, spare_rx_data} : {rx2_bit, rx2_data, 2'h0},
				{rx_bit_in_3, rx_data_in_3, rx_bit_in_2, rx_data_in_2})
			`CHK("tx feeds", s ? {2'h0, tx_out_second_1, tx_out_second_0} : {tx_out_second_1, tx_out_second_0, 2'h0},
				{tx2_feed, spare_tx_feed})
			`CHK("jams", c ? {counter_a_jam_1, 1'h0, counter_b_jam_1, 1'h0} : {1'h0, counter_a_jam_0, 1'h0,
				counter_b_jam_0}, {counter_a_jam, counter_b_jam})
			`CHK("clock_sync", {4{c ? clock_sync_pulse_1 : clock_sync_pulse_0}}, clock_sync)
			`CHK("quiet scan", c ? {quiet_scan_src_1, 1'h0} : {1'h0, quiet_scan_src_0}, {quiet_scan_1, quiet_scan_0})
			`CHK("maint_line", c ? maint_src_1 : maint_src_0, maint_line)
			`CHK("switch strobes", c ? {clock_strobe_1, 11'h000} : {11'h000, clock_strobe_0},
				{switch_strobe_1, switch_strobe_0})
			`CHK("clock power", {!c, c, c, !c}, {clock0_power, clock0_ground, clock1_power, clock1_ground})
			`CHK("scan_point_260", scanner_active, scan_point_260)
		end
		$display("test %s done", name);
	endtask
	task automatic ev(input logic [1:0] dc, input bit sb, input bit ns, input bit nc);
		int k;
		w = '{default: 0};
		dc_on = dc;
		k = 0;
		while (k < 60 && (sb ? failover_strobe_b : failover_strobe_a) !== 1'b1) begin
			@(posedge clock);
			#1;
			k++;
		end
		`CHK("strobe", 1'b1, sb ? failover_strobe_b : failover_strobe_a)
		s = ns;
		c = nc;
		for (k = 1; k < 1500; k++) begin
			@(posedge clock);
			#1;
			if (k == DL + UP - 6)
				`CHK("verify_261 early", 1'b0, verify_261)
			if (k == DL + UP + 8)
				`CHK("verify_261", nc, verify_261)
		end
		for (k = 0; k < 10; k++)
			`CHK("pulse width", exp_w(k, sb), w[k])
		$display("test strobe event done");
	endtask
	initial begin
		put(63'h0);
		repeat (4) @(posedge clock);
		#1;
		rst_b = 1;
		cyc(20, "normal");
		ev(2'h1, 1, 1, 1);
		cyc(30, "second link");
		ev(2'h3, 1, 0, 0);
		cyc(10, "restore second");
		lag = 4'h6;
		ev(2'h2, 0, 0, 1);
		cyc(30, "first link slow");
		ev(2'h3, 0, 0, 0);
		cyc(10, "restore first");
		dc_on = 2'h0;
		repeat (40) @(posedge clock);
		#1;
		cyc(20, "both released");
		stop_test();
	end
	initial begin
		#(8 * 12000);
		fail_count++;
		$display("watchdog expired");
		stop_test();
	end
endmodule
`default_nettype wire

/* tb/failover_chk.sv */
// concurrent checks on the link failover top ports
`timescale 1ns/10ps
`default_nettype none
module failover_chk
	import failover_pkg::*;
#(
	parameter count_t HOLD_CYCLES = 20,
	parameter count_t DELAY_CYCLES = 30,
	parameter count_t UPDATE_CYCLES = 40,
	parameter count_t MASK_CYCLES = 15
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic link1_supervision_relay,
	input wire logic link3_supervision_relay,
	input wire logic link3_in,
	input wire logic scanner_active,
	input wire logic rx2_line,
	input wire logic trunk13_circuit_line,
	input wire logic second_link_transfer,
	input wire logic common_transfer,
	input wire logic failover_strobe_a,
	input wire logic failover_strobe_b,
	input wire logic verify_clamp,
	input wire logic verify_261,
	input wire logic delayed_start_0,
	input wire logic update_inhibit_0,
	input wire logic message_send_hold,
	input wire logic scan_point_260,
	input wire logic clock0_power,
	input wire logic clock0_ground,
	input wire logic clock1_power,
	input wire logic clock1_ground,
	input wire logic [3:0] clock_hold,
	input wire logic [3:0] mask
);
	localparam int D_LO = DELAY_CYCLES - 2;
	localparam int D_HI = DELAY_CYCLES + 3;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	// routing lags the transfer flag by one edge, hence three samples
	sequence s_slt;
		second_link_transfer[*3];
	endsequence
	sequence s_drop0;
		clock0_ground && !clock0_power && !clock1_power;
	endsequence
	sequence s_up1;
		clock1_power && !clock1_ground;
	endsequence
	a_strobe_width: assert property ($rose(failover_strobe_a) |-> failover_strobe_a[*8] ##[1:4] !failover_strobe_a)
		else $error("strobe a width wrong");
	a_both_idle: assert property ((!link1_supervision_relay && !link3_supervision_relay)[*8] |-> !common_transfer)
		else $error("transfer with both relays released");
	a_slt_cause: assert property ($rose(second_link_transfer) |->
		$past(link1_supervision_relay, 2) && !$past(link3_supervision_relay, 2))
		else $error("second link transfer without cause");
	a_rx_route: assert property (s_slt |-> !rx2_line && trunk13_circuit_line == $past(link3_in))
		else $error("link three not rerouted");
	a_clamp_set: assert property ($rose(failover_strobe_a || failover_strobe_b) |-> ##[0:1] verify_clamp)
		else $error("clamp not set");
	a_clamp_hides: assert property (verify_clamp && $past(verify_clamp) |-> !verify_261)
		else $error("verify shown while clamped");
	a_chain_wait: assert property ($rose(verify_261) |-> common_transfer && $past(common_transfer, 6))
		else $error("verify before chain complete");
	a_delay_start: assert property ($rose(failover_strobe_a) |-> ##[D_LO:D_HI] $rose(delayed_start_0))
		else $error("delayed start late or missing");
	a_update_start: assert property ($rose(delayed_start_0) |-> ##[0:1] update_inhibit_0)
		else $error("update inhibit not started");
	a_send_hold: assert property ($rose(update_inhibit_0) |-> ##1 message_send_hold)
		else $error("sending not held");
	a_scan_follow: assert property ($changed(scanner_active) |-> ##1 $changed(scan_point_260))
		else $error("scan point 260 not following");
	a_power_order: assert property ($fell(clock0_power) |-> s_drop0 ##1 s_up1)
		else $error("clock power handover order");
	a_mask_pairs: assert property (mask[0] == mask[1] && mask[2] == mask[3])
		else $error("mask pair split");
	a_hold_together: assert property (clock_hold == 4'h0 || clock_hold == 4'hf)
		else $error("clock holds not all four together");
endmodule
bind link_failover failover_chk #(.HOLD_CYCLES(HOLD_CYCLES), .DELAY_CYCLES(DELAY_CYCLES),
	.UPDATE_CYCLES(UPDATE_CYCLES), .MASK_CYCLES(MASK_CYCLES)) chk (.*);
`default_nettype wire
